// ==== test/pcsev_far_end.sv ====
// pcsev_far_end: transaction, link and retry-buffer stand-in for the selector's event ports.
// assumes the bench holds go high for one cycle per packet, with the beat to send.
`timescale 1ns/10ps
`default_nettype none
module pcsev_far_end
	import pcsev_pkg::*;
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// requests
	input  wire logic        go,
	input  wire pcsev_tx_s   tx_in,
	input  wire pcsev_rx_s   rx_in,
	input  wire pcsev_link_s lk_in,
	// event ports
	output var pcsev_tx_s    tx_beat,
	output var pcsev_rx_s    rx_beat,
	output var pcsev_link_s  link_ev
);
	localparam int TXB = $bits(pcsev_tx_s);
	localparam int RXB = $bits(pcsev_rx_s);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_beat <= '0;
			rx_beat <= '0;
			link_ev <= '0;
		end else if (go) begin
			tx_beat <= tx_in;
			rx_beat <= rx_in;
			link_ev <= lk_in;
		end else begin
			// qualifiers low, other fields churn so stale values are never trusted
			tx_beat <= {3'h0, ~tx_beat[TXB-4:0]};
			rx_beat <= {4'h0, ~rx_beat[RXB-5:0]};
			link_ev <= '0;
		end
	end
endmodule : pcsev_far_end
`default_nettype wire

// ==== test/pcsev_stat_select_bench.sv ====
// pcsev_stat_select_bench: event table, then placement, stop, pairing, credit and reset cases.
// assumes the far-end model; each send makes two back-to-back packets.
`timescale 1ns/10ps
`default_nettype none
module pcsev_stat_select_bench
	import pcsev_pkg::*;
;
	typedef struct packed {
		logic [7:0] c;
		logic [1:0] src;
		pcsev_tlp_e k;
		logic [2:0] f;
		logic [4:0] t;
		logic       np;
		logic       rp;
		logic [1:0] d;
		logic [3:0] e;
	} pcsev_row_s;
	logic                       pclk, presetn, psel, penable, pwrite, pready, pslverr, err, go, counters_running;
	logic [15:0]                paddr;
	logic [31:0]                pwdata, prdata, q;
	logic [11:0]                retry_level;
	logic [N_RCRED-1:0][11:0]   rcred;
	logic [N_LCRED-1:0][11:0]   lcred;
	pcsev_tx_s                  tx_in, tx_beat;
	pcsev_rx_s                  rx_in, rx_beat;
	pcsev_link_s                lk_in, link_ev;
	int                         n_fail, checks, cyc;
	pcsev_row_s rows [20] = '{
		'{8'h00, 0, PCSEV_TLP_MEM, 0, 0, 0, 0, 2, 4},
		'{8'h00, 0, PCSEV_TLP_MEM, 0, 0, 0, 1, 2, 0},
		'{8'h01, 0, PCSEV_TLP_CPL, 0, 0, 0, 0, 1, 2},
		'{8'h02, 0, PCSEV_TLP_MSG, 0, 0, 0, 0, 1, 2},
		'{8'h03, 0, PCSEV_TLP_MEM, 1, 0, 0, 0, 1, 2},
		'{8'h04, 0, PCSEV_TLP_MEM, 0, 0, 1, 0, 1, 2},
		'{8'h05, 0, PCSEV_TLP_MEM, 1, 0, 0, 0, 1, 0},
		'{8'h06, 0, PCSEV_TLP_MEM, 5, 11, 0, 0, 1, 2},
		'{8'h06, 0, PCSEV_TLP_MEM, 5, 10, 0, 0, 1, 0},
		'{8'h1a, 1, PCSEV_TLP_IO, 0, 0, 0, 0, 1, 2},
		'{8'h1b, 1, PCSEV_TLP_CPL, 0, 0, 0, 0, 1, 2},
		'{8'h1c, 1, PCSEV_TLP_CPL, 1, 0, 0, 0, 1, 2},
		'{8'h20, 3, PCSEV_TLP_OTHER, 0, 0, 0, 0, 0, 8},// clock
		'{8'h1d, 1, PCSEV_TLP_CPL, 5, 11, 0, 0, 1, 2},
		'{8'h21, 2, PCSEV_TLP_MEM, 0, 0, 0, 0, 1, 2},
		'{8'h25, 0, PCSEV_TLP_CPL, 0, 0, 0, 0, 2, 4},
		'{8'h26, 1, PCSEV_TLP_MSG, 0, 0, 0, 0, 1, 2},
		'{8'h27, 3, PCSEV_TLP_OTHER, 0, 8, 0, 0, 0, 2},
		'{8'h28, 3, PCSEV_TLP_OTHER, 0, 4, 0, 0, 0, 2},
		'{8'h29, 3, PCSEV_TLP_OTHER, 0, 2, 0, 0, 0, 2}
	};
	pcsev_stat_select i_pcsev_stat_select (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.tx_beat(tx_beat), .rx_beat(rx_beat), .link_ev(link_ev), .retry_level(retry_level),
		.remote_credits(rcred), .local_credits(lcred), .counters_running(counters_running));
	pcsev_far_end i_pcsev_far_end (.pclk(pclk), .presetn(presetn), .go(go), .tx_in(tx_in), .rx_in(rx_in),
		.lk_in(lk_in), .tx_beat(tx_beat), .rx_beat(rx_beat), .link_ev(link_ev));
	always #4 pclk = ~pclk;
	task wrap_up;
		if (n_fail == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : wrap_up
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			wrap_up();
		end
	end
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask : apb
	task send(input pcsev_row_s r);
		@(posedge pclk);
		tx_in <= '{r.src == 0, r.src == 0, r.rp, r.k, r.np, r.f, r.t, r.d, r.d};
		rx_in <= '{r.src == 1, r.src == 1, 1'b1, r.src == 2, r.k, r.f, r.t, r.d};
		lk_in <= (r.src == 3) ? r.t[3:0] : 4'h0;
		go <= 1'b1;
		repeat (2) @(posedge pclk);
		go <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask : send
	task cnts(input logic [3:0][7:0] ex);
		for (int n = 0; n < 4; n++) begin
			apb(1'b0, ADDR_CNT0 + 16'(4 * n), 32'h0);
			chk("counter", {24'h0, ex[n]}, q);
		end
	endtask : cnts
	initial begin
		pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0; go = 0;
		tx_in = '0; rx_in = '0; lk_in = '0; retry_level = 12'h004; rcred = {5{12'h020}}; lcred = {3{12'h005}};
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b1, ADDR_FTAG, 32'h0000_00ab);
		foreach (rows[i]) begin
			apb(1'b1, ADDR_EVSEL, {24'h0, rows[i].c});
			apb(1'b1, ADDR_CTRL, 32'ha000_0001);
			send(rows[i]);
			apb(1'b0, ADDR_CNT0, 32'h0);
			chk("count", {28'h0, rows[i].e}, q);
		end
		apb(1'b1, ADDR_EVSEL, 32'h0100_2107);
		apb(1'b0, ADDR_EVSEL, 32'h0);
		chk("evsel", 32'h0100_2107, q);
		apb(1'b1, ADDR_CTRL, 32'ha000_0007);
		send(rows[2]);
		cnts({8'h0, 8'h2, 8'h0, 8'h0});
		apb(1'b1, ADDR_CTRL, 32'h4000_0007);
		send(rows[2]);
		cnts({8'h0, 8'h2, 8'h0, 8'h0});
		apb(1'b1, ADDR_CTRL, 32'h8000_0007);
		send(rows[2]);
		cnts({8'h0, 8'h4, 8'h0, 8'h0});
		apb(1'b1, ADDR_EVSEL, 32'h0000_0101);
		apb(1'b1, ADDR_CTRL, 32'hb000_0003);
		send(rows[2]);
		cnts({8'h0, 8'h0, 8'h0, 8'h2});
		apb(1'b1, ADDR_RTHR, 32'h0000_0010);
		apb(1'b1, ADDR_THR0, 32'h0000_0008);
		apb(1'b1, ADDR_EVSEL, 32'h2c30_2b2a);
		apb(1'b1, ADDR_CTRL, 32'ha000_000f);
		rcred[0] <= 12'h005;
		lcred[0] <= 12'h000;
		send('{8'h0, 3, PCSEV_TLP_OTHER, 0, 1, 0, 0, 0, 0});
		cnts({8'h0, 8'h1, 8'h1, 8'h2});
		apb(1'b1, ADDR_THR1, 32'h0008_0008);
		apb(1'b1, ADDR_THR2, 32'h0000_0008);
		apb(1'b1, ADDR_EVSEL, 32'h322f_2e2d);
		apb(1'b1, ADDR_CTRL, 32'ha000_000f);
		rcred[4:2] <= {3{12'h005}};
		lcred[2] <= 12'h000;
		repeat (4) @(posedge pclk);
		cnts({8'h1, 8'h1, 8'h1, 8'h1});
		apb(1'b0, 16'h5b40, 32'h0);
		chk("slverr", 32'h1, {31'h0, err});
		chk("unmapped", 32'h0, q);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, ADDR_EVSEL, 32'h0);
		chk("evsel", 32'h0, q);
		cnts('0);
		wrap_up();
	end
endmodule : pcsev_stat_select_bench
`default_nettype wire

// ==== test/pcsev_stat_select_monitor.sv ====
// pcsev_stat_select_monitor: apb and run-state checks on the selector's ports.
// assumes one pclk domain; counter values are judged by the bench.
`timescale 1ns/10ps
`default_nettype none
module pcsev_stat_select_monitor
	import pcsev_pkg::*;
(
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// state
	input wire logic        counters_running
);
	logic        wr_ctrl;
	logic        rd_setup;
	logic [31:0] evsel_reg;
	assign wr_ctrl  = psel && penable && pwrite && paddr == ADDR_CTRL;
	assign rd_setup = psel && !penable && !pwrite;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// shadow of the last software write, so read-back is judged across time
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evsel_reg <= REG_RESET;
		end else if (psel && penable && pwrite && paddr == ADDR_EVSEL) begin
			evsel_reg <= pwdata;
		end
	end
	property p_evsel_rd;
		rd_setup && paddr == ADDR_EVSEL |=> prdata == evsel_reg;
	endproperty
	a_evsel_rd: assert property (p_evsel_rd) else $error("event select read-back wrong");
	property p_start;
		wr_ctrl && pwdata[CTRL_START] && !pwdata[CTRL_STOP] |=> counters_running;
	endproperty
	a_start: assert property (p_start) else $error("start did not run counters");
	property p_stop;
		wr_ctrl && pwdata[CTRL_STOP] |=> !counters_running [*2];
	endproperty
	a_stop: assert property (p_stop) else $error("stop did not halt counters");
	property p_run_hold;
		!wr_ctrl |=> $stable(counters_running);
	endproperty
	a_run_hold: assert property (p_run_hold) else $error("run state moved without write");
	property p_ctrl_w1;
		rd_setup && paddr == ADDR_CTRL |=> prdata[31:29] == 3'h0;
	endproperty
	a_ctrl_w1: assert property (p_ctrl_w1) else $error("command bits read back set");
	property p_err;
		psel && !penable && paddr == 16'h5b40 ##1 penable |-> pslverr;
	endproperty
	a_err: assert property (p_err) else $error("unmapped access without error");
	property p_no_err;
		psel && !penable && paddr == ADDR_EVSEL |=> !pslverr;
	endproperty
	a_no_err: assert property (p_no_err) else $error("error on mapped access");
	property p_wr_zero;
		psel && !penable && pwrite |=> prdata == 32'h0;
	endproperty
	a_wr_zero: assert property (p_wr_zero) else $error("read data not zero on write");
	property p_err_idle;
		!(psel && penable) |-> !pslverr;
	endproperty
	a_err_idle: assert property (p_err_idle) else $error("error outside access phase");
	c_start: cover property (wr_ctrl && pwdata[CTRL_START]);
	c_err: cover property (psel && penable && pslverr);
	c_pair: cover property (wr_ctrl && pwdata[CTRL_PAIR]);
endmodule : pcsev_stat_select_monitor
bind pcsev_stat_select pcsev_stat_select_monitor i_pcsev_stat_select_monitor (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .counters_running(counters_running));
`default_nettype wire

// ==== verilog/pcsev_counter.sv ====
// pcsev_counter: one statistic counter with synchronous clear and a wrap carry.
// assumes the increment is already gated by run and enable.
`timescale 1ns/10ps
`default_nettype none
module pcsev_counter
	import pcsev_pkg::*;
#(
	parameter int W = CNT_W
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// control
	input  wire logic         clear,
	input  wire logic [1:0]   inc,
	// state
	output logic [W-1:0]      value,
	output logic              carry
);

	logic [W:0] sum;

	assign sum   = {1'b0, value} + {{(W-1){1'b0}}, inc};
	assign carry = sum[W];

	// clear beats a same-cycle increment
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			value <= '0;
		end else if (clear) begin
			value <= '0;
		end else begin
			value <= sum[W-1:0];
		end
	end

endmodule : pcsev_counter
`default_nettype wire

// ==== verilog/pcsev_event_mux.sv ====
// pcsev_event_mux: turns one counter's event code into an increment of 0 to 3.
// assumes conditioned events arrive already qualified by packet type and replay.
`timescale 1ns/10ps
`default_nettype none
module pcsev_event_mux
	import pcsev_pkg::*;
(
	// selection
	input  wire logic [EV_W-1:0]   event_code,
	input  wire logic [FUNC_W-1:0] match_func,
	input  wire logic [TAG_W-1:0]  match_tag,
	// events
	input  wire pcsev_ev_s         ev,
	// increment
	output logic [1:0]             inc
);

	logic tx_match;
	logic rx_match;

	assign tx_match = ev.tx_memmsg && ev.tx_func == match_func && ev.tx_tag == match_tag;
	assign rx_match = ev.rx_cpl && ev.rx_func == match_func && ev.rx_tag == match_tag;

	always_comb begin
		inc = 2'h0;
		unique case (event_code)
			EV_TX_DW:      inc = ev.tx_dw;
			EV_TX_PKT:     inc = {1'b0, ev.tx_pkt};
			EV_TX_F0:      inc = {1'b0, ev.tx_f0};
			EV_TX_F1:      inc = {1'b0, ev.tx_f1};
			EV_TX_NP_F0:   inc = {1'b0, ev.tx_np_f0};
			EV_TX_NP_F1:   inc = {1'b0, ev.tx_np_f1};
			EV_TX_FTAG:    inc = {1'b0, tx_match};
			EV_RX_PKT:     inc = {1'b0, ev.rx_pkt};
			EV_RX_CPL_F0:  inc = {1'b0, ev.rx_cpl_f0};
			EV_RX_CPL_F1:  inc = {1'b0, ev.rx_cpl_f1};
			EV_RX_FTAG:    inc = {1'b0, rx_match};
			EV_CLOCK:      inc = 2'h1;
			EV_RX_BAD:     inc = {1'b0, ev.rx_bad};
			EV_TX_HDR:     inc = ev.tx_hdr;
			EV_RX_HDR:     inc = ev.rx_hdr;
			EV_STALL_CRED: inc = {1'b0, ev.stall_credit};
			EV_RETRANS:    inc = {1'b0, ev.retransmit};
			EV_STALL_FULL: inc = {1'b0, ev.stall_full};
			EV_RETRY_LOW:  inc = {1'b0, ev.retry_low};
			EV_RCRED_PH:   inc = {1'b0, ev.rcred_low[0]};
			EV_RCRED_PD:   inc = {1'b0, ev.rcred_low[1]};
			EV_RCRED_NPH:  inc = {1'b0, ev.rcred_low[2]};
			EV_RCRED_COMPLETION_HEADER_CREDITS: inc = {1'b0, ev.rcred_low[3]};
			EV_RCRED_COMPLETION_DATA_CREDITS: inc = {1'b0, ev.rcred_low[4]};
			EV_LCRED_PH:   inc = {1'b0, ev.lcred_zero[0]};
			EV_LCRED_NPH:  inc = {1'b0, ev.lcred_zero[1]};
			EV_LCRED_PD:   inc = {1'b0, ev.lcred_zero[2]};
			default:       inc = 2'h0;
		endcase
	end

endmodule : pcsev_event_mux
`default_nettype wire

// ==== verilog/pcsev_pkg.sv ====
// pcsev_pkg: register map, event codes and event carriers for the statistic event selector.
// assumes a 16-bit apb byte address and one 125 MHz clock shared with the event sources.
package pcsev_pkg;

	localparam int N_CNT      = 4;
	localparam int CNT_W      = 32;
	localparam int CRED_W     = 12;
	localparam int EV_W       = 8;
	localparam int FUNC_W     = 3;
	localparam int TAG_W      = 5;
	localparam int FUNC_LSB   = 5;
	localparam int THR_HI_LSB = 16;
	localparam int N_RCRED    = 5;
	localparam int N_LCRED    = 3;

	// byte addresses
	localparam logic [15:0] ADDR_CTRL  = 16'h5b10;
	localparam logic [15:0] ADDR_EVSEL = 16'h5b14;
	localparam logic [15:0] ADDR_FTAG  = 16'h5b18;
	localparam logic [15:0] ADDR_RTHR  = 16'h5b1c;
	localparam logic [15:0] ADDR_THR0  = 16'h5b20;
	localparam logic [15:0] ADDR_THR1  = 16'h5b24;
	localparam logic [15:0] ADDR_THR2  = 16'h5b28;
	localparam logic [15:0] ADDR_CNT0  = 16'h5b30;

	// control register fields
	localparam int CTRL_START = 31;
	localparam int CTRL_STOP  = 30;
	localparam int CTRL_CLEAR = 29;
	localparam int CTRL_PAIR  = 28;
	localparam int CTRL_TEST  = 27;
	localparam int CTRL_EN0   = 0;

	localparam logic [31:0] REG_RESET = 32'h0000_0000;
	localparam logic [2:0]  FUNC0     = 3'h0;
	localparam logic [2:0]  FUNC1     = 3'h1;

	// event codes
	localparam logic [7:0] EV_TX_DW      = 8'h00;
	localparam logic [7:0] EV_TX_PKT     = 8'h01;
	localparam logic [7:0] EV_TX_F0      = 8'h02;
	localparam logic [7:0] EV_TX_F1      = 8'h03;
	localparam logic [7:0] EV_TX_NP_F0   = 8'h04;
	localparam logic [7:0] EV_TX_NP_F1   = 8'h05;
	localparam logic [7:0] EV_TX_FTAG    = 8'h06;
	localparam logic [7:0] EV_RX_PKT     = 8'h1a;
	localparam logic [7:0] EV_RX_CPL_F0  = 8'h1b;
	localparam logic [7:0] EV_RX_CPL_F1  = 8'h1c;
	localparam logic [7:0] EV_RX_FTAG    = 8'h1d;
	localparam logic [7:0] EV_CLOCK      = 8'h20;
	localparam logic [7:0] EV_RX_BAD     = 8'h21;
	localparam logic [7:0] EV_TX_HDR     = 8'h25;
	localparam logic [7:0] EV_RX_HDR     = 8'h26;
	localparam logic [7:0] EV_STALL_CRED = 8'h27;
	localparam logic [7:0] EV_RETRANS    = 8'h28;
	localparam logic [7:0] EV_STALL_FULL = 8'h29;
	localparam logic [7:0] EV_RETRY_LOW  = 8'h2a;
	localparam logic [7:0] EV_RCRED_PH   = 8'h2b;
	localparam logic [7:0] EV_RCRED_PD   = 8'h2c;
	localparam logic [7:0] EV_RCRED_NPH  = 8'h2d;
	localparam logic [7:0] EV_RCRED_COMPLETION_HEADER_CREDITS = 8'h2e;
	localparam logic [7:0] EV_RCRED_COMPLETION_DATA_CREDITS = 8'h2f;
	localparam logic [7:0] EV_LCRED_PH   = 8'h30;
	localparam logic [7:0] EV_LCRED_NPH  = 8'h31;
	localparam logic [7:0] EV_LCRED_PD   = 8'h32;

	typedef enum logic [2:0] {
		PCSEV_TLP_OTHER,
		PCSEV_TLP_CPL,
		PCSEV_TLP_MEM,
		PCSEV_TLP_MSG,
		PCSEV_TLP_IO,
		PCSEV_TLP_CFG
	} pcsev_tlp_e;

	// transmit beat towards the physical layer
	typedef struct packed {
		logic       valid;
		logic       start;
		logic       replay;
		pcsev_tlp_e kind;
		logic       nonposted;
		logic [2:0] func;
		logic [4:0] tag;
		logic [1:0] dw;
		logic [1:0] hdr_dw;
	} pcsev_tx_s;

	// receive beat from the link layer
	typedef struct packed {
		logic       valid;
		logic       start;
		logic       good;
		logic       bad;
		pcsev_tlp_e kind;
		logic [2:0] func;
		logic [4:0] tag;
		logic [1:0] hdr_dw;
	} pcsev_rx_s;

	// one-cycle pulses from transaction layer and retry buffer
	typedef struct packed {
		logic stall_credit;
		logic retransmit;
		logic stall_full;
		logic retry_pkt;
	} pcsev_link_s;

	// conditioned per-cycle events shared by all counters
	typedef struct packed {
		logic [1:0] tx_dw;
		logic       tx_pkt;
		logic       tx_memmsg;
		logic       tx_f0;
		logic       tx_f1;
		logic       tx_np_f0;
		logic       tx_np_f1;
		logic [2:0] tx_func;
		logic [4:0] tx_tag;
		logic       rx_pkt;
		logic       rx_cpl;
		logic       rx_cpl_f0;
		logic       rx_cpl_f1;
		logic [2:0] rx_func;
		logic [4:0] rx_tag;
		logic       rx_bad;
		logic [1:0] tx_hdr;
		logic [1:0] rx_hdr;
		logic       stall_credit;
		logic       retransmit;
		logic       stall_full;
		logic       retry_low;
		logic [4:0] rcred_low;
		logic [2:0] lcred_zero;
	} pcsev_ev_s;

endpackage : pcsev_pkg

// ==== verilog/pcsev_stat_select.sv ====
// pcsev_stat_select: apb register file, event conditioning and four statistic counters.
// assumes transaction, link and retry-buffer sources run on pclk and pulse once per packet.
`timescale 1ns/10ps
`default_nettype none
module pcsev_stat_select
	import pcsev_pkg::*;
#(
	parameter int CW = CRED_W
) (
	// clock and reset
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	// apb slave
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [15:0]                 paddr,
	input  wire logic [31:0]                 pwdata,
	output logic [31:0]                      prdata,
	output logic                             pready,
	output logic                             pslverr,
	// event sources
	input  wire pcsev_tx_s                   tx_beat,
	input  wire pcsev_rx_s                   rx_beat,
	input  wire pcsev_link_s                 link_ev,
	input  wire logic [CW-1:0]               retry_level,
	input  wire logic [N_RCRED-1:0][CW-1:0]  remote_credits,
	input  wire logic [N_LCRED-1:0][CW-1:0]  local_credits,
	// state
	output logic                             counters_running
);

	// register state
	logic [31:0]                      evsel_reg;
	logic [31:0]                      ftag_reg;
	logic [CW-1:0]                    retry_thr_reg;
	logic [N_RCRED-1:0][CW-1:0]       thr_reg;
	logic                             pair_reg;
	logic                             test_reg;
	logic [N_CNT-1:0]                 enable_reg;
	logic                             run_reg;
	logic [31:0]                      prdata_reg;
	logic                             err_reg;
	logic [N_RCRED-1:0]               rlow_reg;
	logic [N_LCRED-1:0]               lzero_reg;

	// bus decode
	logic                             setup;
	logic                             wr;
	logic                             wr_ctrl;
	logic                             hit;
	logic [31:0]                      rd_data;
	logic                             counters_start;
	logic                             counters_stop;
	logic                             counters_clear;

	// event path
	pcsev_ev_s                        ev;
	logic                             tx_ok;
	logic                             tx_cmm;
	logic                             tx_mm;
	logic                             rx_cmm;
	logic [N_RCRED-1:0]               rlow_now;
	logic [N_LCRED-1:0]               lzero_now;
	logic [N_CNT-1:0][1:0]            sel_inc;
	logic [N_CNT-1:0][1:0]            cnt_inc;
	logic [N_CNT-1:0][CNT_W-1:0]      cnt_val;
	logic [N_CNT-1:0]                 cnt_carry;

	// zero-wait slave: read data and error are captured in the setup cycle
	assign setup   = psel && !penable;
	assign wr      = psel && penable && pwrite && !err_reg;
	assign wr_ctrl = wr && paddr == ADDR_CTRL;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && err_reg;
	assign prdata  = prdata_reg;

	assign counters_start   = wr_ctrl && pwdata[CTRL_START];
	assign counters_stop    = wr_ctrl && pwdata[CTRL_STOP];
	assign counters_clear   = wr_ctrl && pwdata[CTRL_CLEAR];
	assign counters_running = run_reg;

	always_comb begin
		rd_data = 32'h0000_0000;
		hit     = 1'b1;
		if (paddr[15:4] == ADDR_CNT0[15:4]) begin
			rd_data = cnt_val[paddr[3:2]];
		end else begin
			unique case (paddr)
				ADDR_CTRL: begin
					rd_data[CTRL_PAIR]                = pair_reg;
					rd_data[CTRL_TEST]                = test_reg;
					rd_data[CTRL_EN0 +: N_CNT]        = enable_reg;
				end
				ADDR_EVSEL: begin
					rd_data = evsel_reg;
				end
				ADDR_FTAG: begin
					rd_data = ftag_reg;
				end
				ADDR_RTHR: begin
					rd_data[CW-1:0] = retry_thr_reg;
				end
				ADDR_THR0: begin
					rd_data[CW-1:0]                = thr_reg[0];
					rd_data[THR_HI_LSB +: CW]      = thr_reg[1];
				end
				ADDR_THR1: begin
					rd_data[CW-1:0]                = thr_reg[2];
					rd_data[THR_HI_LSB +: CW]      = thr_reg[3];
				end
				ADDR_THR2:  rd_data[CW-1:0] = thr_reg[4];
				default:    hit = 1'b0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= REG_RESET;
		end else if (setup) begin
			prdata_reg <= pwrite ? REG_RESET : rd_data;
		end
	end

	// error decided at setup, so pslverr needs no address decode in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_reg <= 1'b0;
		end else if (setup) begin
			err_reg <= !hit;
		end
	end

	// event selection register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evsel_reg <= REG_RESET;
		end else if (wr && paddr == ADDR_EVSEL) begin
			evsel_reg <= pwdata;
		end
	end

	// function and tag match values
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ftag_reg <= REG_RESET;
		end else if (wr && paddr == ADDR_FTAG) begin
			ftag_reg <= pwdata;
		end
	end

	// retry-buffer threshold
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			retry_thr_reg <= '0;
		end else if (wr && paddr == ADDR_RTHR) begin
			retry_thr_reg <= pwdata[CW-1:0];
		end
	end

	// credit thresholds
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			thr_reg <= '0;
		end else if (wr) begin
			if (paddr == ADDR_THR0) begin
				thr_reg[0] <= pwdata[CW-1:0];
				thr_reg[1] <= pwdata[THR_HI_LSB +: CW];
			end
			if (paddr == ADDR_THR1) begin
				thr_reg[2] <= pwdata[CW-1:0];
				thr_reg[3] <= pwdata[THR_HI_LSB +: CW];
			end
			if (paddr == ADDR_THR2) begin
				thr_reg[4] <= pwdata[CW-1:0];
			end
		end
	end

	// control: start, stop and clear are self-clearing, they read as zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pair_reg <= 1'b0;
		end else if (wr_ctrl) begin
			pair_reg <= pwdata[CTRL_PAIR];
		end
	end

	// test bit is storage only, counting ignores it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			test_reg <= 1'b0;
		end else if (wr_ctrl) begin
			test_reg <= pwdata[CTRL_TEST];
		end
	end

	// per-counter enables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_reg <= '0;
		end else if (wr_ctrl) begin
			enable_reg <= pwdata[CTRL_EN0 +: N_CNT];
		end
	end

	// stop wins when both start and stop are written together
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_reg <= 1'b0;
		end else if (counters_stop) begin
			run_reg <= 1'b0;
		end else if (counters_start) begin
			run_reg <= 1'b1;
		end
	end

	// transmit conditioning: replays never count as new traffic
	assign tx_ok  = tx_beat.valid && tx_beat.start && !tx_beat.replay;
	assign tx_mm  = tx_beat.kind == PCSEV_TLP_MEM || tx_beat.kind == PCSEV_TLP_MSG;
	assign tx_cmm = tx_mm || tx_beat.kind == PCSEV_TLP_CPL;
	assign rx_cmm = rx_beat.kind == PCSEV_TLP_CPL || rx_beat.kind == PCSEV_TLP_MEM
		|| rx_beat.kind == PCSEV_TLP_MSG;

	// credit edges, history reset high so power-up levels never count
	generate
		for (genvar gr = 0; gr < N_RCRED; gr++) begin : g_rcred
			assign rlow_now[gr] = remote_credits[gr] < thr_reg[gr];
		end
		for (genvar gl = 0; gl < N_LCRED; gl++) begin : g_lcred
			assign lzero_now[gl] = local_credits[gl] == '0;
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rlow_reg  <= '1;
			lzero_reg <= '1;
		end else begin
			rlow_reg  <= rlow_now;
			lzero_reg <= lzero_now;
		end
	end

	always_comb begin
		ev              = '0;
		ev.tx_dw        = (tx_beat.valid && !tx_beat.replay && tx_cmm) ? tx_beat.dw : 2'h0;
		ev.tx_pkt       = tx_ok && tx_cmm;
		ev.tx_memmsg    = tx_ok && tx_mm;
		ev.tx_f0        = tx_ok && tx_mm && tx_beat.func == FUNC0;
		ev.tx_f1        = tx_ok && tx_mm && tx_beat.func == FUNC1;
		ev.tx_np_f0     = tx_ok && tx_beat.kind == PCSEV_TLP_MEM && tx_beat.nonposted
			&& tx_beat.func == FUNC0;
		ev.tx_np_f1     = tx_ok && tx_beat.kind == PCSEV_TLP_MEM && tx_beat.nonposted
			&& tx_beat.func == FUNC1;
		ev.tx_func      = tx_beat.func;
		ev.tx_tag       = tx_beat.tag;

		// receive side
		ev.rx_cpl       = rx_beat.valid && rx_beat.start && rx_beat.good
			&& rx_beat.kind == PCSEV_TLP_CPL;
		ev.rx_pkt       = ev.rx_cpl || (rx_beat.valid && rx_beat.start
			&& (rx_beat.kind == PCSEV_TLP_MEM || rx_beat.kind == PCSEV_TLP_IO
			|| rx_beat.kind == PCSEV_TLP_CFG));
		ev.rx_cpl_f0    = ev.rx_cpl && rx_beat.func == FUNC0;
		ev.rx_cpl_f1    = ev.rx_cpl && rx_beat.func == FUNC1;
		ev.rx_func      = rx_beat.func;
		ev.rx_tag       = rx_beat.tag;
		ev.rx_bad       = rx_beat.bad;
		ev.tx_hdr       = (tx_beat.valid && !tx_beat.replay && tx_cmm) ? tx_beat.hdr_dw : 2'h0;
		ev.rx_hdr       = (rx_beat.valid && rx_cmm) ? rx_beat.hdr_dw : 2'h0;

		// link, retry buffer and credit events
		ev.stall_credit = link_ev.stall_credit;
		ev.retransmit   = link_ev.retransmit;
		ev.stall_full   = link_ev.stall_full;
		ev.retry_low    = link_ev.retry_pkt && retry_level < retry_thr_reg;
		ev.rcred_low    = rlow_now & ~rlow_reg;
		ev.lcred_zero   = lzero_now & ~lzero_reg;
	end

	// per-counter selection and counting
	generate
		for (genvar gi = 0; gi < N_CNT; gi++) begin : g_cnt
			logic [1:0] gated;

			pcsev_event_mux u_mux (
				.event_code (evsel_reg[gi*EV_W +: EV_W]),
				.match_func (ftag_reg[gi*EV_W+FUNC_LSB +: FUNC_W]),
				.match_tag  (ftag_reg[gi*EV_W +: TAG_W]),
				.ev         (ev),
				.inc        (sel_inc[gi])
			);

			assign gated = (run_reg && enable_reg[gi]) ? sel_inc[gi] : 2'h0;

			// odd counter becomes the upper half of its even neighbour
			if (gi % 2 == 1) begin : g_hi
				assign cnt_inc[gi] = pair_reg ? {1'b0, cnt_carry[gi-1]} : gated;
			end else begin : g_lo
				assign cnt_inc[gi] = gated;
			end

			pcsev_counter #(
				.W (CNT_W)
			) u_cnt (
				.pclk    (pclk),
				.presetn (presetn),
				.clear   (counters_clear),
				.inc     (cnt_inc[gi]),
				.value   (cnt_val[gi]),
				.carry   (cnt_carry[gi])
			);
		end
	endgenerate

endmodule : pcsev_stat_select
`default_nettype wire
